// >>> bench/lacb_exec_bench.sv
// self-checking bench for the and/carry-branch executor
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
   fails++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module lacb_exec_bench
   import lacb_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [APB_AW-1:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h00000000;
   logic pready_o;
   logic [31:0] prdata_o;
   logic pslverr_o;
   logic busy_o;
   logic [PC_W-1:0] pc_o;
   logic [31:0] rdat;
   logic rerr;
   int fails = 0;
   int check_count = 0;

   lacb_exec i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
      .pc_o(pc_o));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // one apb transfer, answer taken at the edge that sees pready
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 40);
      if (n >= 40) fails++;
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : xfer

   task automatic expect_reg(input string nm, input logic [7:0] a,
      input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      `CHK(nm, exp, rdat)
      `CHK("no slverr", 1'b0, rerr)
   endtask : expect_reg

   task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, OFS_MADDR, {20'h00000, a});
      xfer(1'b1, OFS_MDATA, {24'h000000, d});
   endtask : mem_set

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, OFS_MADDR, {20'h00000, a});
      expect_reg("ram byte", OFS_MDATA, {24'h000000, d});
   endtask : mem_chk

   // start an opcode and count the cycles busy stays up
   task automatic run_op(input logic [15:0] op, input int cyc);
      int n;
      // busy rises with pready, one cycle is gone when xfer returns
      n = 1;
      xfer(1'b1, OFS_INSTR, {16'h0000, op});
      @(negedge clk_i);
      while (busy_o === 1'b1 && n < 40) begin
         n++;
         @(negedge clk_i);
      end
      `CHK("busy cycles", cyc, n)
   endtask : run_op

   task automatic t_reset();
      expect_reg("acc reset", OFS_ACC, 32'h00000000);
      expect_reg("pc reset", OFS_PC, 32'h00000000);
      expect_reg("status reset", OFS_STATUS, 32'h00000000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_lit();
      xfer(1'b1, OFS_ACC, 32'h000000a3);
      run_op(16'h0b5f, 4);
      expect_reg("acc and k", OFS_ACC, 32'h00000003);
      expect_reg("flags clear", OFS_STATUS, 32'h00000000);
      run_op(16'h0b00, 4);
      expect_reg("zero flag", OFS_STATUS, 32'h00000004);
      xfer(1'b1, OFS_ACC, 32'h000000ff);
      run_op(16'h0b80, 4);
      expect_reg("acc neg", OFS_ACC, 32'h00000080);
      expect_reg("neg flag", OFS_STATUS, 32'h00000010);
      $display("test literal and done");
   endtask : t_lit

   task automatic t_file();
      mem_set(12'h010, 8'hc2);
      xfer(1'b1, OFS_ACC, 32'h00000017);
      run_op(16'h1410, 4);
      expect_reg("acc file", OFS_ACC, 32'h00000002);
      mem_chk(12'h010, 8'hc2);
      mem_set(12'h340, 8'hf0);
      xfer(1'b1, OFS_BANK, 32'h00000003);
      xfer(1'b1, OFS_ACC, 32'h0000009c);
      run_op(16'h1740, 4);
      mem_chk(12'h340, 8'h90);
      expect_reg("acc kept", OFS_ACC, 32'h0000009c);
      expect_reg("neg file", OFS_STATUS, 32'h00000010);
      mem_set(12'hf80, 8'h0f);
      run_op(16'h1680, 4);
      mem_chk(12'hf80, 8'h0c);
      $display("test file and done");
   endtask : t_file

   task automatic t_ext();
      mem_set(12'h005, 8'hff);
      mem_set(12'h205, 8'h3c);
      xfer(1'b1, OFS_CTRL, 32'h00000001);
      xfer(1'b1, OFS_IDX, 32'h00000200);
      xfer(1'b1, OFS_ACC, 32'h0000000f);
      run_op(16'h1605, 4);
      mem_chk(12'h205, 8'h0c);
      mem_chk(12'h005, 8'hff);
      xfer(1'b1, OFS_CTRL, 32'h00000000);
      $display("test indexed done");
   endtask : t_ext

   task automatic t_branch();
      xfer(1'b1, OFS_STATUS, 32'h00000011);
      xfer(1'b1, OFS_PC, 32'h00000100);
      run_op(16'he2fe, 8);
      `CHK("pc back", 21'h0000fe, pc_o)
      run_op(16'he27f, 8);
      `CHK("pc fwd", 21'h0001fe, pc_o)
      expect_reg("flags kept", OFS_STATUS, 32'h00000011);
      xfer(1'b1, OFS_STATUS, 32'h00000004);
      run_op(16'he280, 4);
      `CHK("pc not taken", 21'h000200, pc_o)
      expect_reg("flags kept", OFS_STATUS, 32'h00000004);
      $display("test branch done");
   endtask : t_branch

   task automatic t_err();
      xfer(1'b0, 8'h24, 32'h00000000);
      `CHK("slverr rd", 1'b1, rerr)
      `CHK("rd data", 32'h00000000, rdat)
      xfer(1'b1, 8'h30, 32'h000000ff);
      `CHK("slverr wr", 1'b1, rerr)
      run_op(16'hffff, 4);
      expect_reg("ill flag", OFS_STATUS, 32'h00000204);
      $display("test unmapped done");
   endtask : t_err

   // clock enable low freezes an op in flight
   task automatic t_hold();
      xfer(1'b1, OFS_PC, 32'h00000040);
      xfer(1'b1, OFS_ACC, 32'h0000003c);
      xfer(1'b1, OFS_INSTR, 32'h00000b0f);
      ce_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("busy held", 1'b1, busy_o)
      `CHK("pc held", 21'h000042, pc_o)
      @(posedge clk_i);
      ce_i <= 1'b1;
      expect_reg("acc after hold", OFS_ACC, 32'h0000000c);
      `CHK("pc after hold", 21'h000042, pc_o)
      $display("test clock enable done");
   endtask : t_hold

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #200000;
      fails++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_lit();
      t_file();
      t_ext();
      t_branch();
      t_err();
      t_hold();
      final_report();
   end
endmodule : lacb_exec_bench

// >>> core/lacb_exec.sv
// executor for the and-with-file, and-with-literal and branch-on-carry ops
//
// Operation
// - conj_file_op ands the accumulator with a file byte, opcode 0001_01da.
// - bank bit 0 uses the access bank, 1 forms {bank_pointer, f}.
// - extended set, bank bit 0 and f <= 95 use indexed literal offset.
// - branch_if_carry_op (1110_0010 n) loads pc + 2 + 2n when carry is 1.
// - the offset is signed, doubled and added to the advanced pc.
// - a taken branch writes pc in quarter 4 then spends a full nop cycle.
// - conj_literal_op ands the accumulator with k, written in quarter 4.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module lacb_exec
   import lacb_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // core state
   output logic busy_o,
   output logic [PC_W-1:0] pc_o
);

   typedef struct packed {
      lacb_state_t st;
      logic [1:0] nopq;
      lacb_kind_t kind;
      logic [INSTR_W-1:0] instr;
      logic [DATA_W-1:0] acc;
      logic flag_c;
      logic flag_z;
      logic flag_n;
      logic ill;
      logic busy;
      logic ext;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] idx;
      logic [PC_W-1:0] pc;
      logic [DATA_W-1:0] opnd;
      logic [PC_W-1:0] tgt;
      logic [ADDR_W-1:0] maddr;
      logic rd_pend;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lacb_exec_state_t;

   lacb_exec_state_t s_q, s_d;
   logic [ADDR_W-1:0] mem_addr;
   logic mem_re;
   logic mem_we;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W-1:0] mem_rdata;
   logic apb_req;
   logic [DATA_W-1:0] and_res;
   logic [ADDR_W-1:0] file_addr;

   lacb_ram u_ram (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .addr_i(mem_addr),
      .re_i(mem_re),
      .we_i(mem_we),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   always_comb begin
      s_d = s_q;
      and_res = s_q.acc & s_q.opnd;
      file_addr = lacb_eff_addr(s_q.instr, s_q.bank, s_q.idx, s_q.ext);
      mem_addr = s_q.maddr;
      mem_re = 1'b0;
      mem_we = 1'b0;
      mem_wdata = pwdata_i[DATA_W-1:0];
      apb_req = psel_i && !s_q.pready && !s_q.rd_pend && s_q.st == ST_IDLE;
      if (s_q.pready) begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
      if (s_q.rd_pend) begin
         s_d.prdata = {24'h000000, mem_rdata};
         s_d.pready = 1'b1;
         s_d.rd_pend = 1'b0;
      end
      if (apb_req) begin
         s_d.pready = 1'b1;
         s_d.pslverr = 1'b0;
         s_d.prdata = '0;
         if (pwrite_i) begin
            case (paddr_i)
               OFS_CTRL: s_d.ext = pwdata_i[CTRL_EXT_BIT];
               OFS_INSTR: begin
                  s_d.instr = pwdata_i[INSTR_W-1:0];
                  s_d.st = ST_Q1;
                  s_d.busy = 1'b1;
               end
               OFS_ACC: s_d.acc = pwdata_i[DATA_W-1:0];
               OFS_STATUS: begin
                  s_d.flag_c = pwdata_i[ST_C_BIT];
                  s_d.flag_z = pwdata_i[ST_Z_BIT];
                  s_d.flag_n = pwdata_i[ST_N_BIT];
                  s_d.ill = pwdata_i[ST_ILL_BIT];
               end
               OFS_BANK: s_d.bank = pwdata_i[BANK_W-1:0];
               OFS_IDX: s_d.idx = pwdata_i[ADDR_W-1:0];
               OFS_PC: s_d.pc = pwdata_i[PC_W-1:0];
               OFS_MADDR: s_d.maddr = pwdata_i[ADDR_W-1:0];
               OFS_MDATA: mem_we = 1'b1;
               default: s_d.pslverr = 1'b1;
            endcase
         end else begin
            case (paddr_i)
               OFS_CTRL: s_d.prdata[CTRL_EXT_BIT] = s_q.ext;
               OFS_INSTR: s_d.prdata[INSTR_W-1:0] = s_q.instr;
               OFS_ACC: s_d.prdata[DATA_W-1:0] = s_q.acc;
               OFS_STATUS: begin
                  s_d.prdata[ST_C_BIT] = s_q.flag_c;
                  s_d.prdata[ST_Z_BIT] = s_q.flag_z;
                  s_d.prdata[ST_N_BIT] = s_q.flag_n;
                  s_d.prdata[ST_BUSY_BIT] = s_q.busy;
                  s_d.prdata[ST_ILL_BIT] = s_q.ill;
               end
               OFS_BANK: s_d.prdata[BANK_W-1:0] = s_q.bank;
               OFS_IDX: s_d.prdata[ADDR_W-1:0] = s_q.idx;
               OFS_PC: s_d.prdata[PC_W-1:0] = s_q.pc;
               OFS_MADDR: s_d.prdata[ADDR_W-1:0] = s_q.maddr;
               OFS_MDATA: begin
                  mem_re = 1'b1;
                  s_d.rd_pend = 1'b1;
                  s_d.pready = 1'b0;
               end
               default: s_d.pslverr = 1'b1;
            endcase
         end
      end
      case (s_q.st)
         ST_IDLE: ;
         ST_Q1: begin
            s_d.kind = lacb_decode(s_q.instr);
            s_d.ill = (lacb_decode(s_q.instr) == K_NONE);
            // pc advances past the fetched word
            s_d.pc = PC_W'(s_q.pc + PC_STEP);
            s_d.st = ST_Q2;
         end
         ST_Q2: begin
            if (s_q.kind == K_FILE) begin
               mem_addr = file_addr;
               mem_re = 1'b1;
            end
            s_d.st = ST_Q3;
         end
         ST_Q3: begin
            s_d.opnd = (s_q.kind == K_FILE) ? mem_rdata : s_q.instr[7:0];
            s_d.tgt = PC_W'(s_q.pc + lacb_rel(s_q.instr[7:0]));
            s_d.st = ST_Q4;
         end
         ST_Q4: begin
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            case (s_q.kind)
               K_FILE, K_LIT: begin
                  if (s_q.kind == K_FILE && s_q.instr[DEST_BIT]) begin
                     mem_addr = file_addr;
                     mem_we = 1'b1;
                     mem_wdata = and_res;
                  end else begin
                     s_d.acc = and_res;
                  end
                  s_d.flag_n = and_res[DATA_W-1];
                  s_d.flag_z = (and_res == '0);
               end
               K_BRC: begin
                  if (s_q.flag_c) begin
                     s_d.pc = s_q.tgt;
                     s_d.st = ST_NOP;
                     s_d.busy = 1'b1;
                     s_d.nopq = 2'h0;
                  end
               end
               default: ;
            endcase
         end
         ST_NOP: begin
            s_d.nopq = 2'(s_q.nopq + 2'h1);
            if (s_q.nopq == LAST_QUARTER) begin
               s_d.st = ST_IDLE;
               s_d.busy = 1'b0;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.kind <= K_NONE;
         s_q.pc <= PC_RST;
         s_q.acc <= ACC_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign pready_o = s_q.pready;
   assign prdata_o = s_q.prdata;
   assign pslverr_o = s_q.pslverr;
   assign busy_o = s_q.busy;
   assign pc_o = s_q.pc;

   default clocking cb @(posedge clk_i iff ce_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence q4_taken;
      s_q.st == ST_Q4 && s_q.kind == K_BRC && s_q.flag_c;
   endsequence
   sequence nop_cycle;
      (s_q.st == ST_NOP) [*4] ##1 (s_q.st == ST_IDLE);
   endsequence

   a_file_acc_dest: assert property (
      s_q.st == ST_Q4 && s_q.kind == K_FILE && !s_q.instr[DEST_BIT]
      |=> s_q.acc == $past(s_q.acc & s_q.opnd))
      else $error("file and result not placed in accumulator");
   a_file_mem_dest: assert property (
      s_q.st == ST_Q4 && s_q.kind == K_FILE && s_q.instr[DEST_BIT]
      |-> mem_we && mem_wdata == (s_q.acc & s_q.opnd)
      ##1 s_q.acc == $past(s_q.acc))
      else $error("file and result not written back to file");
   a_bank_addr: assert property (
      s_q.st == ST_Q2 && s_q.kind == K_FILE && s_q.instr[BANKSEL_BIT]
      |-> mem_re && mem_addr == {s_q.bank, s_q.instr[7:0]})
      else $error("banked address wrong");
   a_indexed_addr: assert property (
      s_q.st == ST_Q2 && s_q.kind == K_FILE && !s_q.instr[BANKSEL_BIT]
      && s_q.ext && s_q.instr[7:0] <= ACCESS_LAST
      |-> mem_addr == ADDR_W'(s_q.idx + ADDR_W'(s_q.instr[7:0])))
      else $error("indexed literal offset address wrong");
   a_branch_target: assert property (
      s_q.st == ST_Q1 && lacb_decode(s_q.instr) == K_BRC && s_q.flag_c
      |-> ##3 s_q.st == ST_Q4 ##1
      s_q.pc == PC_W'($past(s_q.pc, 4) + PC_STEP
      + lacb_rel(s_q.instr[7:0])))
      else $error("branch target wrong");
   a_pc_advance: assert property (
      s_q.st == ST_Q1 |=> s_q.pc == PC_W'($past(s_q.pc) + PC_STEP))
      else $error("pc did not advance past instruction");
   a_branch_nop: assert property (
      q4_taken |=> nop_cycle)
      else $error("taken branch nop cycle wrong");
   a_branch_untaken: assert property (
      s_q.st == ST_Q4 && s_q.kind == K_BRC && !s_q.flag_c
      |=> s_q.st == ST_IDLE && $stable(s_q.pc))
      else $error("untaken branch altered pc or stalled");
   a_lit_and: assert property (
      s_q.st == ST_Q1 && lacb_decode(s_q.instr) == K_LIT
      |-> ##4 s_q.acc == ($past(s_q.acc, 4) & s_q.instr[7:0]))
      else $error("literal and result wrong");
   a_flags_and: assert property (
      s_q.st == ST_Q4 && (s_q.kind == K_LIT || s_q.kind == K_FILE)
      |=> s_q.flag_n == $past(and_res[DATA_W-1])
      && s_q.flag_z == ($past(and_res) == '0))
      else $error("n or z flag wrong after and");
   a_flags_branch: assert property (
      s_q.st == ST_Q1 && lacb_decode(s_q.instr) == K_BRC
      |=> $stable({s_q.flag_c, s_q.flag_z, s_q.flag_n}) [*4])
      else $error("branch changed a status flag");

endmodule : lacb_exec

// >>> core/lacb_pkg.sv
// constants, types and decode helpers for the and/carry-branch executor
package lacb_pkg;

   // widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned BANK_W = 4;
   localparam int unsigned PC_W = 21;
   localparam int unsigned INSTR_W = 16;
   localparam int unsigned APB_AW = 8;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_ACC = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_BANK = 8'h10;
   localparam logic [7:0] OFS_IDX = 8'h14;
   localparam logic [7:0] OFS_PC = 8'h18;
   localparam logic [7:0] OFS_MADDR = 8'h1c;
   localparam logic [7:0] OFS_MDATA = 8'h20;

   // field positions
   localparam int unsigned CTRL_EXT_BIT = 0;
   localparam int unsigned ST_C_BIT = 0;
   localparam int unsigned ST_Z_BIT = 2;
   localparam int unsigned ST_N_BIT = 4;
   localparam int unsigned ST_BUSY_BIT = 8;
   localparam int unsigned ST_ILL_BIT = 9;
   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned BANKSEL_BIT = 8;

   // opcode patterns
   localparam logic [5:0] FILE_AND_PAT = 6'h05;
   localparam logic [7:0] LIT_AND_PAT = 8'h0b;
   localparam logic [7:0] BR_CARRY_PAT = 8'he2;

   // access bank split and page of its upper half
   localparam logic [7:0] ACCESS_LAST = 8'h5f;
   localparam logic [3:0] SFR_PAGE = 4'hf;

   // timing: quarters of one instruction cycle
   localparam logic [1:0] LAST_QUARTER = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   // reset values
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

   typedef enum {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_NOP} lacb_state_t;
   typedef enum {K_NONE, K_FILE, K_LIT, K_BRC} lacb_kind_t;

   function automatic lacb_kind_t lacb_decode(input logic [15:0] ins);
      if (ins[15:10] == FILE_AND_PAT) return K_FILE;
      else if (ins[15:8] == LIT_AND_PAT) return K_LIT;
      else if (ins[15:8] == BR_CARRY_PAT) return K_BRC;
      else return K_NONE;
   endfunction : lacb_decode

   function automatic logic [ADDR_W-1:0] lacb_eff_addr(
      input logic [15:0] ins,
      input logic [BANK_W-1:0] bank,
      input logic [ADDR_W-1:0] idx,
      input logic ext);
      logic [7:0] f;
      f = ins[7:0];
      if (ins[BANKSEL_BIT]) return {bank, f};
      else if (ext && f <= ACCESS_LAST) return ADDR_W'(idx + ADDR_W'(f));
      else if (f <= ACCESS_LAST) return {4'h0, f};
      else return {SFR_PAGE, f};
   endfunction : lacb_eff_addr

   function automatic logic [PC_W-1:0] lacb_rel(input logic [7:0] n);
      return {{(PC_W-9){n[7]}}, n, 1'b0};
   endfunction : lacb_rel

endpackage : lacb_pkg

// >>> core/lacb_ram.sv
// data memory with registered read port
`timescale 1ns/1ps
module lacb_ram
   import lacb_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // access port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic re_i,
   input wire logic we_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o
);
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } lacb_ram_state_t;

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   lacb_ram_state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (re_i) begin
         s_d.rdata = mem[addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = s_q.rdata;
endmodule : lacb_ram
